/* hdl/sfr_top.sv */
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none

module sfr_top #(
	parameter int MAX_CAL = 256
) (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic                     link_clock_in,
	input  wire logic                     link_data_in,
	input  wire logic                     link_sync_in,
	input  wire logic                     force_xoff_on_crc_error,
	output logic      [MAX_CAL-1:0]       received_channel_flow_bits,
	output logic                          intf_health,
	output logic      [sfr_pkg::LANES-1:0] lane_health,
	output logic                          crc_error,
	output logic                          rate_overrun,
	output logic      [(MAX_CAL+63)/64-1:0] group_update
);
	import sfr_pkg::*;

	localparam int GROUPS = (MAX_CAL + WORD_DATA_BITS - 1) / WORD_DATA_BITS;

	// ----------------------------------------------------------------
	// Reset synchronisers
	// ----------------------------------------------------------------
	logic [1:0] link_rst_sync;
	logic [1:0] user_rst_sync;
	logic       link_rst_n;
	logic       user_rst_n;

	// Asserted at once, released on each domain's own clock
	always_ff @(posedge link_clock_in or negedge presetn) begin
		if (!presetn) link_rst_sync <= 2'b00;
		else          link_rst_sync <= {link_rst_sync[0], 1'b1};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) user_rst_sync <= 2'b00;
		else          user_rst_sync <= {user_rst_sync[0], 1'b1};
	end

	assign link_rst_n = link_rst_sync[1];
	assign user_rst_n = user_rst_sync[1];

	// ----------------------------------------------------------------
	// Link domain: double-rate capture
	// ----------------------------------------------------------------
	logic rise_data;
	logic rise_sync;
	logic fall_data;
	logic fall_sync;

	// Rising-edge half of each bit pair
	always_ff @(posedge link_clock_in or negedge link_rst_n) begin
		if (!link_rst_n) begin
			rise_data <= 1'b0;
			rise_sync <= 1'b0;
		end else begin
			rise_data <= link_data_in;
			rise_sync <= link_sync_in;
		end
	end

	// Falling-edge half; same clock, so no synchroniser needed
	always_ff @(negedge link_clock_in or negedge link_rst_n) begin
		if (!link_rst_n) begin
			fall_data <= 1'b0;
			fall_sync <= 1'b0;
		end else begin
			fall_data <= link_data_in;
			fall_sync <= link_sync_in;
		end
	end

	// ----------------------------------------------------------------
	// Link domain: word assembly and CRC
	// ----------------------------------------------------------------
	logic [5:0]                pair_cnt;
	logic                      aligned;
	logic [3:0]                crc;
	logic [3:0]                rx_crc;
	logic [WORD_DATA_BITS-1:0] shift_data;
	logic                      word_status;
	logic [IDX_W-1:0]          word_idx;
	logic [5:0]                pos;
	logic                      start;
	logic [3:0]                next_crc;
	logic [3:0]                next_rx_crc;
	logic [WORD_DATA_BITS-1:0] next_data;
	logic                      word_done;

	function automatic logic [3:0] crc_step(input logic [3:0] c, input logic b);
		logic fb;
		fb = c[3] ^ b;
		crc_step = {c[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
	endfunction : crc_step

	// Sync high on the rising half of a pair restarts the word; the pair is bit 0 and 1
	always_comb begin
		start       = rise_sync;
		pos         = start ? 6'h00 : pair_cnt;
		next_crc    = start ? CRC_INIT : crc;
		next_rx_crc = rx_crc;
		next_data   = shift_data;
		if (pos < DATA_PAIRS) begin
			next_data[{pos[4:0], 1'b0}] = rise_data;
			next_data[{pos[4:0], 1'b1}] = fall_data;
			next_crc = crc_step(crc_step(next_crc, rise_data), fall_data);
		end else begin
			next_rx_crc = {rx_crc[1:0], rise_data, fall_data};
		end
		word_done = (aligned || start) && (pos == LAST_PAIR);
	end

	logic      [1:0] ack_sync;
	logic            ack_tgl;
	logic            req_tgl;
	logic            overrun_sticky;
	sfr_word_s       xfer_word;
	logic            pending;

	assign pending = req_tgl ^ ack_sync[1];

	// Bit position, CRC and word kind tracking
	always_ff @(posedge link_clock_in or negedge link_rst_n) begin
		if (!link_rst_n) begin
			pair_cnt    <= 6'h00;
			aligned     <= 1'b0;
			crc         <= CRC_INIT;
			rx_crc      <= 4'h0;
			shift_data  <= '0;
			word_status <= 1'b0;
			word_idx    <= '0;
		end else begin
			shift_data <= next_data;
			rx_crc     <= next_rx_crc;
			if (start) begin
				aligned     <= 1'b1;
				word_status <= fall_sync;
				word_idx    <= '0;
			end
			if (pos == LAST_PAIR) begin
				pair_cnt <= 6'h00;
				crc      <= CRC_INIT;
				if (word_done && !(start ? fall_sync : word_status))
					word_idx <= (start ? '0 : word_idx) + 1'b1;
				if (!start)
					word_status <= 1'b0;
			end else begin
				pair_cnt <= pos + 6'h01;
				crc      <= next_crc;
			end
		end
	end

	// Hand-off register; held still while the user side has not taken it
	always_ff @(posedge link_clock_in or negedge link_rst_n) begin
		if (!link_rst_n) begin
			xfer_word      <= '0;
			req_tgl        <= 1'b0;
			overrun_sticky <= 1'b0;
		end else if (word_done) begin
			if (pending) begin
				overrun_sticky <= 1'b1;
			end else begin
				xfer_word.is_status <= start ? fall_sync : word_status;
				xfer_word.idx       <= start ? '0 : word_idx;
				xfer_word.crc_ok    <= (next_rx_crc == next_crc);
				xfer_word.data      <= next_data;
				req_tgl             <= ~req_tgl;
			end
		end
	end

	// Acknowledge toggle back from the user domain
	always_ff @(posedge link_clock_in or negedge link_rst_n) begin
		if (!link_rst_n) ack_sync <= 2'b00;
		else             ack_sync <= {ack_sync[0], ack_tgl};
	end

	// ----------------------------------------------------------------
	// User domain: crossing
	// ----------------------------------------------------------------
	logic [2:0] req_sync;
	logic [1:0] ovr_sync;
	logic       word_valid;

	always_ff @(posedge pclk or negedge user_rst_n) begin
		if (!user_rst_n) begin
			req_sync <= 3'b000;
			ovr_sync <= 2'b00;
			ack_tgl  <= 1'b0;
		end else begin
			req_sync <= {req_sync[1:0], req_tgl};
			ovr_sync <= {ovr_sync[0], overrun_sticky};
			ack_tgl  <= req_sync[1];
		end
	end

	// Word sat still two cycles before this edge is seen
	assign word_valid = req_sync[1] ^ req_sync[2];

	// ----------------------------------------------------------------
	// User domain: status and calendar update
	// ----------------------------------------------------------------
	logic [31:0]                ctrl;
	logic [31:0]                good_cnt;
	logic [31:0]                bad_cnt;
	logic [GROUPS*64-1:0]       cal_bits;
	logic                       force_stop;
	logic                       good_word;
	logic                       bad_word;
	logic                       healthy;

	assign force_stop = force_xoff_on_crc_error | ctrl[CTRL_FORCE_BIT];
	assign good_word  = word_valid && xfer_word.crc_ok;
	assign bad_word   = word_valid && !xfer_word.crc_ok;
	assign healthy    = intf_health && (&lane_health);

	// Health, error and overrun flags
	always_ff @(posedge pclk or negedge user_rst_n) begin
		if (!user_rst_n) begin
			intf_health  <= 1'b1;
			lane_health  <= '1;
			crc_error    <= 1'b0;
			rate_overrun <= 1'b0;
			good_cnt     <= 32'h0000_0000;
			bad_cnt      <= 32'h0000_0000;
		end else begin
			rate_overrun <= ovr_sync[1];
			if (bad_word) begin
				crc_error <= 1'b1;
				bad_cnt   <= bad_cnt + 32'h0000_0001;
			end else if (good_word) begin
				crc_error <= 1'b0;
				good_cnt  <= good_cnt + 32'h0000_0001;
				if (xfer_word.is_status) begin
					intf_health <= xfer_word.data[STAT_INTF_BIT];
					lane_health <= xfer_word.data[STAT_LANE_LSB +: LANES];
				end
			end
		end
	end

	// One group of 64 calendar bits per generate slot
	for (genvar g = 0; g < GROUPS; g++) begin : g_group
		always_ff @(posedge pclk or negedge user_rst_n) begin
			if (!user_rst_n) begin
				cal_bits[g*64 +: 64] <= '0;
				group_update[g]      <= 1'b0;
			end else begin
				group_update[g] <= 1'b0;
				if (bad_word && force_stop) begin
					cal_bits[g*64 +: 64] <= '0;
				end else if (good_word && !xfer_word.is_status && (xfer_word.idx == IDX_W'(g))) begin
					cal_bits[g*64 +: 64] <= xfer_word.data;
					group_update[g]      <= 1'b1;
				end
			end
		end
	end

	// Masked output register; health loss wins over stored calendar
	always_ff @(posedge pclk or negedge user_rst_n) begin
		if (!user_rst_n) received_channel_flow_bits <= '0;
		else if (!healthy) received_channel_flow_bits <= '0;
		else received_channel_flow_bits <= cal_bits[MAX_CAL-1:0];
	end

	// ----------------------------------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------------------------------
	logic apb_write;
	logic mapped;

	assign apb_write = psel && penable && pwrite;
	assign pready    = 1'b1;
	assign mapped    = (paddr == CTRL_ADDR) || (paddr == STATUS_ADDR) ||
	                   (paddr == GOOD_CNT_ADDR) || (paddr == BAD_CNT_ADDR);
	assign pslverr   = psel && penable && !mapped;

	always_ff @(posedge pclk or negedge user_rst_n) begin
		if (!user_rst_n) ctrl <= CTRL_RESET;
		else if (apb_write && (paddr == CTRL_ADDR)) ctrl <= {31'h0000_0000, pwdata[CTRL_FORCE_BIT]};
	end

	// Read data registered in the setup cycle, ready in the access phase
	always_ff @(posedge pclk or negedge user_rst_n) begin
		if (!user_rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				CTRL_ADDR:     prdata <= ctrl;
				STATUS_ADDR:   prdata <= {17'h0_0000, lane_health, intf_health, rate_overrun, crc_error};
				GOOD_CNT_ADDR: prdata <= good_cnt;
				BAD_CNT_ADDR:  prdata <= bad_cnt;
				default:       prdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule : sfr_top

`default_nettype wire

/* hdl/sfr_pkg.sv */
package sfr_pkg;

	// ----------------------------------------------------------------
	// Link framing
	// ----------------------------------------------------------------
	localparam int          WORD_DATA_BITS = 64;
	localparam int          CRC_BITS       = 4;
	localparam logic [5:0]  LAST_PAIR      = 6'h21;   // 68 bits at two bits per link cycle
	localparam logic [5:0]  DATA_PAIRS     = 6'h20;   // Pairs holding data bits
	localparam logic [3:0]  CRC_INIT       = 4'hF;
	localparam logic [3:0]  CRC_POLY       = 4'h3;    // x^4 + x + 1
	localparam int          IDX_W          = 5;       // Up to 32 calendar groups
	localparam int          LANES          = 12;
	localparam int          STAT_INTF_BIT  = 0;
	localparam int          STAT_LANE_LSB  = 1;

	// ----------------------------------------------------------------
	// Register map (APB byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] CTRL_ADDR      = 12'h000;
	localparam logic [11:0] STATUS_ADDR    = 12'h004;
	localparam logic [11:0] GOOD_CNT_ADDR  = 12'h008;
	localparam logic [11:0] BAD_CNT_ADDR   = 12'h00C;
	localparam int          CTRL_FORCE_BIT = 0;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
	localparam int          ST_CRC_BIT     = 0;
	localparam int          ST_OVR_BIT     = 1;
	localparam int          ST_INTF_BIT    = 2;
	localparam int          ST_LANE_LSB    = 3;

	// ----------------------------------------------------------------
	// Word handed from the link domain to the user domain
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                      is_status;
		logic [IDX_W-1:0]          idx;
		logic                      crc_ok;
		logic [WORD_DATA_BITS-1:0] data;
	} sfr_word_s;

endpackage : sfr_pkg

/* tb/sfr_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module sfr_chk
	import sfr_pkg::*;
#(
	parameter int MAX_CAL = 256
) (
	input wire logic                       pclk,
	input wire logic                       presetn,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [11:0]                paddr,
	input wire logic [31:0]                pwdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	input wire logic                       force_xoff_on_crc_error,
	input wire logic [MAX_CAL-1:0]         received_channel_flow_bits,
	input wire logic                       intf_health,
	input wire logic [sfr_pkg::LANES-1:0]  lane_health,
	input wire logic                       crc_error,
	input wire logic                       rate_overrun,
	input wire logic [(MAX_CAL+63)/64-1:0] group_update
);
	logic ctrl_force;
	logic frc;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// --------
	// Force option as seen from the ports
	// --------
	// Mirror of the control bit, since the register itself is hidden
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_force <= 1'b0;
		else if (psel && penable && pwrite && paddr == CTRL_ADDR)
			ctrl_force <= pwdata[CTRL_FORCE_BIT];
	end
	assign frc = force_xoff_on_crc_error | ctrl_force;
	// --------
	// Properties
	// --------
	property p_intf;
		!intf_health |=> received_channel_flow_bits == '0;
	endproperty
	a_intf: assert property (p_intf) else $error("flow not off with bad interface");
	property p_lane;
		!(&lane_health) |=> received_channel_flow_bits == '0;
	endproperty
	a_lane: assert property (p_lane) else $error("flow not off with bad lane");
	property p_hold;
		crc_error && $past(crc_error) && !frc |-> $stable(received_channel_flow_bits);
	endproperty
	a_hold: assert property (p_hold) else $error("flow moved during checksum error");
	property p_health;
		crc_error && $past(crc_error) |-> $stable(intf_health) && $stable(lane_health);
	endproperty
	a_health: assert property (p_health) else $error("health moved during checksum error");
	property p_force;
		$rose(crc_error) && frc |-> ##[0:3] received_channel_flow_bits == '0;
	endproperty
	a_force: assert property (p_force) else $error("forced stop did not clear flow");
	property p_sticky;
		rate_overrun |=> rate_overrun;
	endproperty
	a_sticky: assert property (p_sticky) else $error("overrun flag dropped");
	property p_rst;
		disable iff (1'b0) !presetn |-> received_channel_flow_bits == '0 && intf_health && (&lane_health)
			&& !crc_error && !rate_overrun && group_update == '0;
	endproperty
	a_rst: assert property (p_rst) else $error("output not at reset value");
	property p_err;
		psel && penable && paddr > BAD_CNT_ADDR |-> pslverr && pready;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_pulse;
		group_update != '0 |=> group_update == '0;
	endproperty
	a_pulse: assert property (p_pulse) else $error("update strobe longer than a cycle");
	c_crc: cover property ($rose(crc_error));
	c_ovr: cover property ($rose(rate_overrun));
	c_lane: cover property ($fell(&lane_health));
endmodule : sfr_chk
`default_nettype wire

/* tb/sfr_link_tx.sv */
`timescale 1ns/10ps
`default_nettype none
module sfr_link_tx
	import sfr_pkg::*;
(
	output var logic lclk,
	output var logic ldat,
	output var logic lsync
);
	// Clock idles low between frames
	initial begin
		lclk = 1'b0;
		ldat = 1'b0;
		lsync = 1'b0;
	end
	// One link cycle: rising-edge bit first, then falling-edge bit
	task automatic cyc(input logic b0, input logic b1, input logic s0, input logic s1);
		ldat = b0;
		lsync = s0;
		#31.25 lclk = 1'b1;
		#31.25 ldat = b1;
		lsync = s1;
		#31.25 lclk = 1'b0;
		#31.25;
	endtask : cyc
	// Free cycles without sync, so the link side leaves reset
	task automatic idle(input int n);
		for (int i = 0; i < n; i++)
			cyc(~ldat, ldat, 1'b0, 1'b0);
	endtask : idle
	// One word; bad spoils a check bit on purpose
	task automatic send(input logic sy, input logic st, input logic [63:0] d, input logic bad);
		logic [3:0]  c;
		logic [67:0] w;
		c = CRC_INIT;
		for (int i = 0; i < WORD_DATA_BITS; i++)
			c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? CRC_POLY : 4'h0);
		w = {c[0] ^ bad, c[1], c[2], c[3], d};
		for (int p = 0; p < 34; p++)
			cyc(w[2*p], w[2*p+1], sy && p == 0, st && p == 0);
		ldat = ~ldat; // Released line must not keep the last bit
	endtask : send
endmodule : sfr_link_tx
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import sfr_pkg::*;
	localparam int MAX_CAL = 128;
	logic         pclk, presetn, psel, penable, pwrite, frc, pready, pslverr, e;
	logic         lclk, ldat, lsync, intf_health, crc_error, rate_overrun;
	logic [11:0]  paddr, lane_health;
	logic [31:0]  pwdata, prdata, r;
	logic [127:0] flow, cur;
	logic [1:0]   gupd;
	logic [64:0]  n;
	logic [64:0]  exp_q[$];
	int           err_count, check_count;
	realtime      hp = 2.0;
	sfr_top #(.MAX_CAL(MAX_CAL)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link_clock_in(lclk), .link_data_in(ldat), .link_sync_in(lsync), .force_xoff_on_crc_error(frc),
		.received_channel_flow_bits(flow), .intf_health(intf_health), .lane_health(lane_health),
		.crc_error(crc_error), .rate_overrun(rate_overrun), .group_update(gupd));
	sfr_link_tx i_tx (.lclk(lclk), .ldat(ldat), .lsync(lsync));
	// User clock; period can be stretched to provoke an overrun
	initial begin
		pclk = 1'b0;
		forever #(hp) pclk = ~pclk;
	end
	// --------
	// Tasks
	// --------
	task automatic check(input string s, input logic [127:0] seen, input logic [127:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", s, exp, seen);
		end
	endtask : check
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Random calendar word; groups past the bus leave no note
	task automatic cal(input logic sy, input int g);
		logic [63:0] d;
		d = {$urandom, $urandom};
		if (g < 2) begin
			exp_q.push_back({g[0], d});
			cur[g*64 +: 64] = d;
		end
		i_tx.send(sy, 1'b0, d, 1'b0);
	endtask : cal
	// Link clock runs one more cycle, since the last bit pair of a word is taken on the next rising edge
	task automatic settle();
		i_tx.idle(1);
		repeat (20) @(posedge pclk);
	endtask : settle
	// Each update strobe takes the oldest note
	initial forever begin
		@(posedge pclk);
		if (gupd !== 2'b00 && exp_q.size() > 0) begin
			n = exp_q.pop_front();
			check("strobe", 128'(gupd), 128'(2'b01 << n[64]));
			repeat (3) @(posedge pclk);
			check("group", 128'(flow[n[64]*64 +: 64]), 128'(n[63:0]));
		end
	end
	// Watchdog
	initial begin
		#200_000; // About two and a half times the expected run length
		err_count++;
		complete_run();
	end
	// --------
	// Tests
	// --------
	initial begin
		presetn = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		frc = 1'b0;
		cur = '0;
		void'($urandom(79));
		// A real falling edge, so no reset flop can miss it at time zero
		@(posedge pclk);
		presetn <= 1'b0;
		i_tx.idle(3);
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		i_tx.idle(4);
		apb(1'b0, CTRL_ADDR, '0);
		check("ctrl", 128'(r), 128'(CTRL_RESET));
		apb(1'b0, STATUS_ADDR, '0);
		check("status", 128'(r), 128'h7FFC);
		apb(1'b1, 12'h010, 32'hFFFF_FFFF);
		check("unmapped", 128'(e), 128'h1);
		$display("test reset done");
		for (int g = 0; g < 3; g++)
			cal(g == 0, g);
		settle();
		check("flow", flow, cur);
		i_tx.send(1'b1, 1'b0, {$urandom, $urandom}, 1'b1);
		settle();
		check("crc", 128'(crc_error), 128'h1);
		check("held", flow, cur);
		cal(1'b1, 0);
		settle();
		check("crc clear", 128'(crc_error), 128'h0);
		apb(1'b0, GOOD_CNT_ADDR, '0);
		check("good count", 128'(r), 128'h4);
		apb(1'b0, BAD_CNT_ADDR, '0);
		check("bad count", 128'(r), 128'h1);
		$display("test calendar done");
		i_tx.send(1'b1, 1'b1, 64'h1FBF, 1'b0);
		settle();
		check("lanes", 128'(lane_health), 128'hFDF);
		check("xoff", flow, '0);
		apb(1'b0, STATUS_ADDR, '0);
		check("status", 128'(r), 128'h7EFC);
		i_tx.send(1'b1, 1'b1, 64'h1FFE, 1'b0);
		settle();
		check("intf", 128'(intf_health), 128'h0);
		check("xoff", flow, '0);
		i_tx.send(1'b1, 1'b1, 64'h1FFF, 1'b0);
		cal(1'b1, 0);
		cal(1'b0, 1);
		settle();
		check("back", flow, cur);
		$display("test health done");
		for (int s = 0; s < 2; s++) begin
			frc <= (s == 0);
			apb(1'b1, CTRL_ADDR, 32'(s));
			apb(1'b0, CTRL_ADDR, '0);
			check("ctrl rw", 128'(r), 128'(s));
			i_tx.send(1'b1, 1'b0, {$urandom, $urandom}, 1'b1);
			settle();
			check("forced", flow, '0);
			frc <= 1'b0;
			apb(1'b1, CTRL_ADDR, '0);
			cur = '0;
			cal(1'b1, 0);
			settle();
		end
		$display("test force done");
		hp = 4000.0; // User clock far too slow, so the overrun cannot be missed
		for (int k = 0; k < 3; k++)
			i_tx.send(k == 0, 1'b0, 64'h0, 1'b0);
		hp = 2.0;
		settle();
		check("overrun", 128'(rate_overrun), 128'h1);
		$display("test overrun done");
		complete_run();
	end
endmodule : testbench
bind sfr_top sfr_chk #(.MAX_CAL(MAX_CAL)) i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.force_xoff_on_crc_error(force_xoff_on_crc_error), .received_channel_flow_bits(received_channel_flow_bits),
	.intf_health(intf_health), .lane_health(lane_health), .crc_error(crc_error),
	.rate_overrun(rate_overrun), .group_update(group_update));
`default_nettype wire
